/* File: ivw_top.sv */
// Interrupt vector selection and halt wake-up qualification with AXI4-Lite registers
// Overview of operation
// - Reset vector 0x008000; reset ends both halts
// - Request n at 0x008008+4n; request 0 never wakes
// - Auto-wakeup ends active halt only
// - Port A request wakes both halts, qualified
// - Ports B to E wake both halts
// - Serial and I2C requests wake both halts
// - Timers, clock, trap never wake; reserved unused
`timescale 1ns/10ps
module ivw_top #(
    parameter int NUM_IRQ = 20
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [ivw_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ivw_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [NUM_IRQ-1:0] IRQ_REQ,
    input wire logic TRAP_REQ,
    input wire logic HALT_MODE,
    input wire logic ACTIVE_HALT_MODE,
    input wire logic VECTOR_ACK,
    output ivw_pkg::ivw_vec_s VECTOR,
    output logic WAKEUP,
    output logic INTERRUPT
);
    import ivw_pkg::*;

    // Wake and reserved masks are fixed at twenty numbers
    if (NUM_IRQ != IRQ_COUNT)
    begin : g_bad_count
        $error("NUM_IRQ must be 20");
    end

    logic [7:0] ext_ctrl1;
    logic [7:0] ext_ctrl2;
    logic [19:0] enable;
    logic [7:0] config_q;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic boot_pending;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [19:0] pend;
    logic [19:0] pend_q;
    logic [19:0] halt_ok;
    logic [19:0] active_ok;
    logic wake_halt;
    logic wake_active;
    logic vec_taken;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic do_write;
    logic [17:0] wr_idx;
    logic [31:0] wr_data;
    logic [31:0] wmask;
    logic [17:0] rd_idx;
    logic [31:0] rd_data;
    logic rd_ok;
    logic wr_ok;
    logic [ST_W-1:0] events;
    logic [ST_W-1:0] next_status;
    ivw_vec_s next_vec;

    // Requests that count: enabled and not on an unused number
    assign pend = IRQ_REQ & enable & ~RESERVED_MASK;

    // Port A wakes only while its qualifying bit is set
    always_comb
    begin
        halt_ok = WAKE_HALT_MASK;
        active_ok = WAKE_ACTIVE_MASK;
        halt_ok[IRQ_PORT_A] = config_q[CFG_PORT_A_WAKE];
        active_ok[IRQ_PORT_A] = config_q[CFG_PORT_A_WAKE];
    end

    // Timers, clock and trap are absent from both masks
    assign wake_halt = HALT_MODE & (|(pend & halt_ok));
    assign wake_active = ACTIVE_HALT_MODE & (|(pend & active_ok));

    // Vector choice: reset first, then trap, then lowest number
    always_comb
    begin
        next_vec = '0;
        if (boot_pending)
        begin
            next_vec.valid = 1'b1;
            next_vec.boot = 1'b1;
            next_vec.addr = VEC_RESET;
        end
        else if (TRAP_REQ)
        begin
            next_vec.valid = 1'b1;
            next_vec.trap = 1'b1;
            next_vec.addr = VEC_TRAP;
        end
        else
        begin
            // Scan downward so the lowest pending number is left
            for (int i = IRQ_COUNT - 1; i >= 0; i--)
            begin
                if (pend[i])
                begin
                    next_vec.valid = 1'b1;
                    next_vec.num = NUM_W'(i);
                end
            end
            next_vec.addr = VEC_IRQ_BASE + {17'h0, next_vec.num, 2'h0};
        end
    end

    assign vec_taken = VECTOR_ACK & VECTOR.valid;

    // Offered vector follows the pending set every cycle
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            VECTOR <= '0;
            pend_q <= '0;
        end
        else
        begin
            VECTOR <= next_vec;
            pend_q <= pend;
        end
    end

    // Reset fetch stays pending until the core takes it
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            boot_pending <= 1'b1;
        else if (vec_taken && VECTOR.boot)
            boot_pending <= 1'b0;
    end

    // Wake request; a pending reset fetch also ends any halt
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            WAKEUP <= 1'b0;
        else
            WAKEUP <= boot_pending | wake_halt | wake_active;
    end

    // Sticky events; a set in the clearing cycle wins
    assign events = {TRAP_REQ, vec_taken, wake_active, wake_halt};
    always_comb
    begin
        next_status = status;
        if (do_write && wr_idx == IDX_STATUS && wmask[0]) // Lane 0, held or live
            next_status = status & ~wr_data[ST_W-1:0];
        next_status = next_status | events;
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            status <= STATUS_RESET;
            INTERRUPT <= 1'b0;
        end
        else
        begin
            status <= next_status;
            INTERRUPT <= |(next_status & mask);
        end
    end

    // Write channel: address and data taken in either order
    assign aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
    assign w_hs = S_AXI_WVALID & S_AXI_WREADY;
    assign do_write = (aw_held | aw_hs) & (w_held | w_hs) & ~S_AXI_BVALID;
    assign wr_idx = aw_held ? awaddr_q[ADDR_W-1:2] : S_AXI_AWADDR[ADDR_W-1:2];
    assign wr_data = w_held ? wdata_q : S_AXI_WDATA;

    // Byte lanes that the write touches
    always_comb
    begin
        wmask = '0;
        for (int b = 0; b < 4; b++)
            wmask[b*8 +: 8] = {8{w_held ? wstrb_q[b] : S_AXI_WSTRB[b]}};
    end

    always_comb
    begin
        case (wr_idx)
            IDX_EXT_CTRL1, IDX_EXT_CTRL2, IDX_ENABLE,
            IDX_CONFIG, IDX_STATUS, IDX_MASK, IDX_VECTOR: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_held <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (w_hs)
            begin
                w_held <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            // Both channels reopen only once the answer is gone
            if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // Stored registers; edge control bytes drive no logic and are only read back
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ext_ctrl1 <= EXT_CTRL_RESET;
            ext_ctrl2 <= EXT_CTRL_RESET;
            enable <= ENABLE_RESET;
            config_q <= CONFIG_RESET;
            mask <= MASK_RESET;
        end
        else if (do_write)
        begin
            case (wr_idx)
                IDX_EXT_CTRL1:
                    ext_ctrl1 <= (ext_ctrl1 & ~wmask[7:0]) | (wr_data[7:0] & wmask[7:0]);
                IDX_EXT_CTRL2:
                    ext_ctrl2 <= (ext_ctrl2 & ~wmask[7:0]) | (wr_data[7:0] & wmask[7:0]);
                IDX_ENABLE:
                    enable <= (enable & ~wmask[19:0]) | (wr_data[19:0] & wmask[19:0]);
                IDX_CONFIG:
                    config_q <= (config_q & ~wmask[7:0]) | (wr_data[7:0] & wmask[7:0]);
                IDX_MASK:
                    mask <= (mask & ~wmask[ST_W-1:0]) | (wr_data[ST_W-1:0] & wmask[ST_W-1:0]);
                default:
                    mask <= mask;
            endcase
        end
    end

    // Read decode; unmapped words answer zero with an error
    assign rd_idx = S_AXI_ARADDR[ADDR_W-1:2];
    always_comb
    begin
        rd_data = '0;
        rd_ok = 1'b1;
        case (rd_idx)
            IDX_EXT_CTRL1: rd_data[7:0] = ext_ctrl1;
            IDX_EXT_CTRL2: rd_data[7:0] = ext_ctrl2;
            IDX_ENABLE: rd_data[19:0] = enable;
            IDX_CONFIG: rd_data[7:0] = config_q;
            IDX_STATUS: rd_data[ST_W-1:0] = status;
            IDX_MASK: rd_data[ST_W-1:0] = mask;
            IDX_VECTOR: rd_data = VECTOR;
            default: rd_ok = 1'b0;
        endcase
    end

    assign ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;

    // Read answer one cycle after the address is taken
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_data;
            S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    reset_vec_a: assert property (VECTOR.boot |-> VECTOR.addr == VEC_RESET)
        else $error("reset vector address wrong");
    boot_wake_a: assert property (boot_pending && !vec_taken |=> WAKEUP)
        else $error("reset fetch did not wake");
    irq_addr_a: assert property (VECTOR.valid && !VECTOR.boot && !VECTOR.trap
        |-> VECTOR.addr == VEC_IRQ_BASE + {17'h0, VECTOR.num, 2'h0})
        else $error("request vector address wrong");
    only_low_a: assert property (!boot_pending && pend == 20'h00001
        |=> !WAKEUP)
        else $error("request 0 woke the device");
    awu_wake_a: assert property (!boot_pending && (pend & ~20'h00002) == '0
        && pend[1] |=> WAKEUP == $past(ACTIVE_HALT_MODE))
        else $error("auto-wakeup wake wrong");
    port_a_a: assert property (HALT_MODE && pend[IRQ_PORT_A]
        && config_q[CFG_PORT_A_WAKE] |=> WAKEUP)
        else $error("port A did not wake");
    ports_be_a: assert property ((HALT_MODE || ACTIVE_HALT_MODE) && |pend[7:4]
        |=> WAKEUP && (status[ST_WAKE_HALT] || status[ST_WAKE_ACTIVE]))
        else $error("port B to E did not wake");
    spi_i2c_a: assert property ((HALT_MODE || ACTIVE_HALT_MODE)
        && (pend[10] || pend[19]) |=> WAKEUP)
        else $error("serial or I2C did not wake");
    no_wake_a: assert property (!boot_pending && (pend & WAKE_ACTIVE_MASK) == '0
        |=> !WAKEUP)
        else $error("non-waking source woke");
    lowest_first_a: assert property (VECTOR.valid && !VECTOR.boot && !VECTOR.trap
        |-> pend_q[VECTOR.num] && (pend_q & ((20'h1 << VECTOR.num) - 20'h1)) == '0)
        else $error("not the lowest pending request");
endmodule : ivw_top

/* File: ivw_pkg.sv */
// Constants, register indices and carrier types for interrupt vector and wake-up logic
package ivw_pkg;
    // Vector area
    localparam logic [23:0] VEC_RESET = 24'h008000;
    localparam logic [23:0] VEC_TRAP = 24'h008004;
    localparam logic [23:0] VEC_IRQ_BASE = 24'h008008;
    localparam int IRQ_COUNT = 20;
    localparam int NUM_W = 5;
    localparam int IRQ_PORT_A = 3;
    // Request numbers that may end plain halt and active halt
    localparam logic [19:0] WAKE_HALT_MASK = 20'h804f8;
    localparam logic [19:0] WAKE_ACTIVE_MASK = 20'h804fa;
    // Numbers 8, 9, 17 and 18 carry no source
    localparam logic [19:0] RESERVED_MASK = 20'h60300;
    // Register indices; byte address is four times the index
    localparam int ADDR_W = 20;
    localparam logic [17:0] IDX_EXT_CTRL1 = 18'h050a0;
    localparam logic [17:0] IDX_EXT_CTRL2 = 18'h050a1;
    localparam logic [17:0] IDX_ENABLE = 18'h05100;
    localparam logic [17:0] IDX_CONFIG = 18'h05101;
    localparam logic [17:0] IDX_STATUS = 18'h05102;
    localparam logic [17:0] IDX_MASK = 18'h05103;
    localparam logic [17:0] IDX_VECTOR = 18'h05104;
    // Reset values
    localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
    localparam logic [19:0] ENABLE_RESET = 20'h00000;
    localparam logic [7:0] CONFIG_RESET = 8'h01;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    // Config bit: port A request qualified for wake-up
    localparam int CFG_PORT_A_WAKE = 0;
    // Status bit positions
    localparam int ST_W = 4;
    localparam int ST_WAKE_HALT = 0;
    localparam int ST_WAKE_ACTIVE = 1;
    localparam int ST_VEC_TAKEN = 2;
    localparam int ST_TRAP = 3;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Vector offered to the core
    typedef struct packed {
        logic valid;
        logic boot;
        logic trap;
        logic [NUM_W-1:0] num;
        logic [23:0] addr;
    } ivw_vec_s;
endpackage : ivw_pkg

/* File: ivw_core_model.sv */
// Behavioural core that takes each offered vector
`timescale 1ns/10ps
module ivw_core_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ack_en,
    input ivw_pkg::ivw_vec_s vector,
    output logic vector_ack
);
    import ivw_pkg::*;
    // One-cycle take; ack_en low models a slow core that leaves the vector waiting
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            vector_ack <= 1'b0;
        else
            vector_ack <= ack_en && vector.valid && !vector_ack;
    end
endmodule : ivw_core_model

/* File: interrupt_vector_wakeup_tb.sv */
// Self-checking bench for vector selection, wake-up and registers
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module interrupt_vector_wakeup_tb;
    import ivw_pkg::*;
    logic clk = 0, resetn = 0, ack_en = 0, ack;
    logic [19:0] awaddr = 0, araddr = 0, irq = 0;
    logic [31:0] wdata = 0, rdata;
    logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic trap = 0, halt = 0, act = 0;
    logic awr, wr_rdy, bv, arr, rv, wake, intr;
    logic [1:0] bresp, rresp, resp;
    ivw_vec_s vec;
    int num_errors = 0, check_count = 0;
    // Per request: bit0 wakes halt, bit1 wakes active halt, bit2 reserved
    logic [2:0] rows [20] = '{0, 2, 0, 3, 3, 3, 3, 3, 4, 4, 3, 0, 0, 0, 0, 0, 0, 4, 4, 3};
    localparam logic [19:0] A_EN = {IDX_ENABLE, 2'b00};
    localparam logic [19:0] A_CFG = {IDX_CONFIG, 2'b00};
    localparam logic [19:0] A_ST = {IDX_STATUS, 2'b00};
    localparam logic [19:0] A_MSK = {IDX_MASK, 2'b00};
    localparam logic [19:0] A_CTL1 = {IDX_EXT_CTRL1, 2'b00};
    localparam logic [19:0] A_CTL2 = {IDX_EXT_CTRL2, 2'b00};

    // 50 MHz clock
    always #10 clk = ~clk;

    ivw_top u_ivw_top (.CLK(clk), .RESETN(resetn), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
        .IRQ_REQ(irq), .TRAP_REQ(trap), .HALT_MODE(halt), .ACTIVE_HALT_MODE(act),
        .VECTOR_ACK(ack), .VECTOR(vec), .WAKEUP(wake), .INTERRUPT(intr));

    ivw_core_model u_ivw_core_model (.clk(clk), .resetn(resetn), .ack_en(ack_en),
        .vector(vec), .vector_ack(ack));

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    // Write with both channels offered together; each dropped once taken
    task automatic axi_wr(input logic [19:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        bready <= 1;
        while (n < 100)
        begin
            @(posedge clk);
            n++;
            if (awv && awr) awv <= 0;
            if (wv && wr_rdy) wv <= 0;
            if (bv && bready)
            begin
                resp = bresp;
                bready <= 0;
                break;
            end
        end
        if (n >= 100) begin num_errors++; complete_run(); end
    endtask : axi_wr

    task automatic axi_rd(input logic [19:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arv <= 1;
        rready <= 1;
        while (n < 100)
        begin
            @(posedge clk);
            n++;
            if (arv && arr) arv <= 0;
            if (rv && rready)
            begin
                d = rdata;
                resp = rresp;
                rready <= 0;
                break;
            end
        end
        if (n >= 100) begin num_errors++; complete_run(); end
    endtask : axi_rd

    // Drive sources and modes, then look once the registered outputs settle
    task automatic drive(input logic [19:0] r, input logic t, h, ah);
        @(posedge clk);
        irq <= r;
        trap <= t;
        halt <= h;
        act <= ah;
        repeat (3) @(posedge clk);
        #1;
    endtask : drive

    // Watchdog for a hung handshake
    initial
    begin
        #200000;
        num_errors++;
        complete_run();
    end

    initial
    begin
        logic [31:0] d;
        repeat (4) @(posedge clk);
        resetn <= 1;
        repeat (2) @(posedge clk);
        #1;
        `CHK({vec.valid, vec.boot, vec.addr}, {2'b11, 24'h008000})
        `CHK(wake, 1'b1)
        `CHK({awr, wr_rdy, arr, bv, rv}, 5'b11100)
        ack_en <= 1;
        axi_rd(A_CFG, d);
        `CHK(d, 32'h1)
        axi_rd(A_EN, d);
        `CHK(d, 32'h0)
        axi_rd(A_CTL2, d);
        `CHK(d, 32'h0)
        axi_wr(A_CTL1, 32'ha5);
        `CHK(resp, RESP_OKAY)
        axi_rd(A_CTL1, d);
        `CHK(d, 32'ha5)
        axi_wr(20'h00010, 32'h1);
        `CHK(resp, RESP_SLVERR)
        axi_rd(20'h00010, d);
        `CHK({resp, d}, {RESP_SLVERR, 32'h0})
        axi_wr(A_EN, 32'hfffff);
        $display("test reset_and_registers done");
        // Table rows: each request alone in plain halt then active halt
        for (int n = 0; n < 20; n++)
        begin
            drive(20'h1 << n, 0, 1, 0);
            `CHK(vec.valid, !rows[n][2])
            if (!rows[n][2])
                `CHK({vec.num, vec.addr}, {5'(n), 24'h008008 + 24'(4 * n)})
            `CHK(wake, rows[n][0])
            drive(20'h1 << n, 0, 0, 1);
            `CHK(wake, rows[n][1])
        end
        $display("test vector_table done");
        drive(20'h80020, 0, 0, 0);
        `CHK(vec.num, 5'd5)
        drive(20'h80300, 0, 0, 0);
        `CHK(vec.addr, 24'h008054)
        drive(20'h00801, 1, 1, 1);
        `CHK({vec.trap, vec.addr, wake}, {1'b1, 24'h008004, 1'b0})
        drive(20'h00001, 0, 1, 1);
        `CHK(wake, 1'b0)
        axi_wr(A_CFG, 32'h0);
        drive(20'h00008, 0, 1, 0);
        `CHK(wake, 1'b0)
        axi_wr(A_CFG, 32'h1);
        drive(20'h00008, 0, 1, 0);
        `CHK(wake, 1'b1)
        $display("test priority_and_qualifier done");
        axi_wr(A_MSK, 32'h4);
        drive(20'h00010, 0, 0, 0);
        drive(20'h0, 0, 0, 0);
        `CHK(intr, 1'b1)
        axi_wr(A_MSK, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        `CHK(intr, 1'b0)
        axi_wr(A_MSK, 32'h4);
        axi_rd(A_ST, d);
        `CHK(d[2], 1'b1)
        axi_wr(A_ST, 32'hf);
        repeat (2) @(posedge clk);
        #1;
        `CHK(intr, 1'b0)
        axi_rd(A_ST, d);
        `CHK(d, 32'h0)
        $display("test interrupt_status done");
        // Mid-run reset: registers return to reset values and the fetch is owed again
        @(posedge clk);
        resetn <= 0;
        @(posedge clk);
        #1;
        `CHK({vec, wake, intr, awr, wr_rdy, arr, bv, rv}, {32'h0, 7'b0011100})
        @(posedge clk);
        resetn <= 1;
        @(posedge clk);
        #1;
        `CHK({vec.valid, vec.boot, vec.addr, wake}, {2'b11, 24'h008000, 1'b1})
        axi_rd(A_MSK, d);
        `CHK(d, 32'h0)
        axi_rd(A_EN, d);
        `CHK(d, 32'h0)
        $display("test mid_run_reset done");
        complete_run();
    end
endmodule : interrupt_vector_wakeup_tb
